//--- logic/wor_event_div.sv
`timescale 1ns/1ps
`include "wor_params.svh"

module wor_event_div #(
    parameter int DIV = `WOR_XOSC_DIV
) (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic run_in,
    // event clock tick
    output logic      tick_out
);
    import wor_pkg::*;

    localparam int CW = $clog2(DIV);

    logic [CW-1:0] div_r;

    // ======================================================================
    // elaboration check
    initial begin
        if (DIV < 2) begin
            $error("wor_event_div: DIV must be at least 2");
        end
    end

    // ======================================================================
    // divide crystal clock down to the event clock
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !run_in) begin
            div_r    <= '0;
            tick_out <= 1'b0;
        end else if (div_r == CW'(DIV - 1)) begin
            div_r    <= '0;
            tick_out <= 1'b1;
        end else begin
            div_r    <= div_r + 1'b1;
            tick_out <= 1'b0;
        end
    end

    // tick spacing helper; parks at all ones so the first running edge wraps it to zero
    logic [CW-1:0] gap_r;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || !run_in) begin
            gap_r <= '1;
        end else if (tick_out) begin
            gap_r <= '0;
        end else begin
            gap_r <= gap_r + 1'b1;
        end
    end

    property p_tick_spacing;
        @(posedge sys_clk_in) disable iff (rst_in)
        (tick_out && $past(run_in) && $past(tick_out) == 1'b0 && gap_r != '0)
            |-> (gap_r == CW'(DIV - 1));
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("event tick spacing differs from divide ratio");

endmodule : wor_event_div

//--- logic/wor_params.svh
`ifndef WOR_PARAMS_SVH
`define WOR_PARAMS_SVH

// ==========================================================================
// register offsets
`define WOR_OFS_EVT0_HI      8'h1e
`define WOR_OFS_EVT0_LO      8'h1f
`define WOR_OFS_CTRL         8'h20
`define WOR_OFS_STATUS       8'h3d
`define WOR_OFS_CMD          8'h3e

// ==========================================================================
// control register field positions
`define WOR_CTRL_PD_BIT      7
`define WOR_CTRL_DLY_HI      6
`define WOR_CTRL_DLY_LO      4
`define WOR_CTRL_CAL_BIT     3
`define WOR_CTRL_RES_HI      1
`define WOR_CTRL_RES_LO      0

// command register bits
`define WOR_CMD_WOR_BIT      0
`define WOR_CMD_RX_BIT       1
`define WOR_CMD_STOP_BIT     2

// ==========================================================================
// reset values
`define WOR_RST_EVT0         16'h876b
`define WOR_RST_PD           1'b1
`define WOR_RST_DLY          3'h7
`define WOR_RST_CAL          1'b1
`define WOR_RST_RES          2'h0

// ==========================================================================
// timing counts
`define WOR_XOSC_DIV         750
`define WOR_CAL_TICKS        8
`define FIRST_EVENT_RESOLUTION_SHIFT        5

`endif

//--- logic/wor_pkg.sv
package wor_pkg;

    // ======================================================================
    // timer modes
    typedef enum logic [1:0] {
        WOR_IDLE,
        WOR_SLEEP,
        WOR_RX_TIMEOUT
    } wor_state_t;

    typedef logic [1:0] first_event_resolution_t;
    typedef logic [2:0] wor_dly_t;

endpackage : wor_pkg

//--- logic/wor_timer.sv
// What this block does
// - The timers run from an event clock equal to the crystal clock divided by 750.
// - The first event fires after 750 crystal periods times the count times 2^(5*resolution).
// - Second-event delay settings 0, 1 and 2 give 4, 6 and 8 event periods after the first.
// - Settings 3 to 7 give 12, 16, 24, 32 and 48 event periods; the delay resets to 7.
// - The calibration enable bit turns calibration at each sleep wake on or off and resets to one; the power-up calibration always runs.
// - Writing the power-down bit to zero starts the oscillator and an initial calibration.
// - Resolution 0 to 3 makes one count worth 1, 32, 1024 or 32768 event periods; resets to 0.
// - The resolution also bounds the longest timeout, up to about 17 hours at setting 3.
// - In receive-timeout mode every resolution setting is accepted and honoured.
`timescale 1ns/1ps
`include "wor_params.svh"

module wor_timer #(
    parameter int DIV       = `WOR_XOSC_DIV,
    parameter int CAL_TICKS = `WOR_CAL_TICKS
) (
    // clock and reset
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_in,
    // register port
    input  wire logic [7:0]            addr_in,
    input  wire logic [7:0]            wr_data_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic      [7:0]            rd_data_out,
    // timer events and status
    output logic                       first_event_count_out,
    output logic                       second_event_delay_out,
    output logic                       cal_busy_out,
    output logic                       osc_on_out,
    output wor_pkg::wor_state_t        state_out
);
    import wor_pkg::*;

    // ======================================================================
    // elaboration check
    initial begin
        if (CAL_TICKS < 1 || CAL_TICKS > 255) begin
            $error("wor_timer: CAL_TICKS must be 1..255");
        end
    end

    // ======================================================================
    // decode helpers
    function automatic logic [5:0] dly_ticks(input wor_dly_t d);
        unique case (d)
            3'h0: dly_ticks = 6'd4;
            3'h1: dly_ticks = 6'd6;
            3'h2: dly_ticks = 6'd8;
            3'h3: dly_ticks = 6'd12;
            3'h4: dly_ticks = 6'd16;
            3'h5: dly_ticks = 6'd24;
            3'h6: dly_ticks = 6'd32;
            3'h7: dly_ticks = 6'd48;
        endcase
    endfunction : dly_ticks

    // last prescale value for one count
    function automatic logic [14:0] pre_last(input first_event_resolution_t r);
        logic [15:0] span;
        span     = 16'h0001 << (`FIRST_EVENT_RESOLUTION_SHIFT * r);
        pre_last = 15'(span - 16'h0001);
    endfunction : pre_last

    // ======================================================================
    // registers
    logic [15:0] evt0_r;
    logic        pd_r;
    wor_dly_t    dly_r;
    logic        cal_en_r;
    first_event_resolution_t    res_r;
    wor_state_t  state_r;
    logic [14:0] pre_r;
    logic [15:0] cnt_r;
    logic        e1_on_r;
    logic [5:0]  e1_cnt_r;
    logic [7:0]  cal_cnt_r;

    logic        tick;
    logic        wr_ctrl;
    logic        pd_wake;
    logic        start_wor;
    logic        start_rx;
    logic        stop;
    logic        unit;
    logic [16:0] evt_eff;
    logic        e0_hit;
    logic        e1_hit;
    logic        cal_start;

    // ======================================================================
    // event clock
    wor_event_div #(
        .DIV        (DIV)
    ) u_div (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .run_in     (!pd_r),
        .tick_out   (tick)
    );

    // ======================================================================
    // write decode
    assign wr_ctrl   = wr_in && (addr_in == `WOR_OFS_CTRL);
    assign pd_wake   = wr_ctrl && pd_r && !wr_data_in[`WOR_CTRL_PD_BIT];
    assign start_wor = wr_in && (addr_in == `WOR_OFS_CMD) && !pd_r
                       && wr_data_in[`WOR_CMD_WOR_BIT];
    assign start_rx  = wr_in && (addr_in == `WOR_OFS_CMD) && !pd_r
                       && !wr_data_in[`WOR_CMD_WOR_BIT] && wr_data_in[`WOR_CMD_RX_BIT];
    assign stop      = (wr_in && (addr_in == `WOR_OFS_CMD) && wr_data_in[`WOR_CMD_STOP_BIT])
                       || pd_r;

    // ======================================================================
    // first-event count registers
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            evt0_r <= `WOR_RST_EVT0;
        end else if (wr_in && addr_in == `WOR_OFS_EVT0_HI) begin
            evt0_r[15:8] <= wr_data_in;
        end else if (wr_in && addr_in == `WOR_OFS_EVT0_LO) begin
            evt0_r[7:0] <= wr_data_in;
        end
    end

    // control register
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pd_r     <= `WOR_RST_PD;
            dly_r    <= `WOR_RST_DLY;
            cal_en_r <= `WOR_RST_CAL;
            res_r    <= `WOR_RST_RES;
        end else if (wr_ctrl) begin
            pd_r     <= wr_data_in[`WOR_CTRL_PD_BIT];
            dly_r    <= wr_data_in[`WOR_CTRL_DLY_HI:`WOR_CTRL_DLY_LO];
            cal_en_r <= wr_data_in[`WOR_CTRL_CAL_BIT];
            res_r    <= wr_data_in[`WOR_CTRL_RES_HI:`WOR_CTRL_RES_LO];
        end
    end

    // ======================================================================
    // mode state; wake-on-radio accepts any resolution, slow ones just sleep long
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_r <= WOR_IDLE;
        end else if (stop) begin
            state_r <= WOR_IDLE;
        end else if (start_wor) begin
            state_r <= WOR_SLEEP;
        end else if (start_rx) begin
            state_r <= WOR_RX_TIMEOUT;
        end else if (e0_hit && state_r == WOR_RX_TIMEOUT) begin
            state_r <= WOR_IDLE;
        end
    end

    // ======================================================================
    // first-event timeout: prescaler then count
    assign unit    = tick && (pre_r == pre_last(res_r));
    assign evt_eff = (evt0_r == 16'h0000) ? 17'h00001 : {1'b0, evt0_r};
    assign e0_hit  = (state_r != WOR_IDLE) && unit
                     && ({1'b0, cnt_r} + 17'h00001 >= evt_eff);

    // prescaler of event ticks
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || start_wor || start_rx || state_r == WOR_IDLE) begin
            pre_r <= '0;
        end else if (unit) begin
            pre_r <= '0;
        end else if (tick) begin
            pre_r <= pre_r + 15'h0001;
        end
    end

    // count of resolution units; full range bounds the longest timeout
    always_ff @(posedge sys_clk_in) begin
        if (rst_in || start_wor || start_rx || state_r == WOR_IDLE) begin
            cnt_r <= '0;
        end else if (e0_hit) begin
            cnt_r <= '0;
        end else if (unit) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // ======================================================================
    // second event after each first event in wake-on-radio mode
    assign e1_hit = e1_on_r && tick && (e1_cnt_r + 6'h01 == dly_ticks(dly_r));

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || stop || start_wor || start_rx) begin
            e1_on_r  <= 1'b0;
            e1_cnt_r <= '0;
        end else if (e0_hit && state_r == WOR_SLEEP) begin
            e1_on_r  <= 1'b1;
            e1_cnt_r <= '0;
        end else if (e1_hit) begin
            e1_on_r  <= 1'b0;
        end else if (e1_on_r && tick) begin
            e1_cnt_r <= e1_cnt_r + 6'h01;
        end
    end

    // ======================================================================
    // oscillator calibration, on wake-up and at each sleep wake when enabled
    assign cal_start = pd_wake || (cal_en_r && e0_hit && state_r == WOR_SLEEP);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cal_cnt_r <= '0;
        end else if (pd_wake) begin
            cal_cnt_r <= 8'(CAL_TICKS);
        end else if (pd_r) begin
            cal_cnt_r <= '0;
        end else if (cal_start) begin
            cal_cnt_r <= 8'(CAL_TICKS);
        end else if (tick && cal_cnt_r != 8'h00) begin
            cal_cnt_r <= cal_cnt_r - 8'h01;
        end
    end

    // ======================================================================
    // registered outputs
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            first_event_count_out   <= 1'b0;
            second_event_delay_out   <= 1'b0;
            cal_busy_out <= 1'b0;
            osc_on_out   <= 1'b0;
            state_out    <= WOR_IDLE;
        end else begin
            first_event_count_out   <= e0_hit;
            second_event_delay_out   <= e1_hit;
            cal_busy_out <= (cal_start || cal_cnt_r != 8'h00) && !pd_r;
            osc_on_out   <= !pd_r;
            state_out    <= state_r;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                `WOR_OFS_EVT0_HI: rd_data_out <= evt0_r[15:8];
                `WOR_OFS_EVT0_LO: rd_data_out <= evt0_r[7:0];
                `WOR_OFS_CTRL:    rd_data_out <= {pd_r, dly_r, cal_en_r, 1'b0, res_r};
                `WOR_OFS_STATUS:  rd_data_out <= {4'h0, !pd_r, cal_cnt_r != 8'h00,
                                                  state_r};
                default:          rd_data_out <= 8'h00;
            endcase
        end else begin
            rd_data_out <= 8'h00;
        end
    end

    // ======================================================================
    // checking helpers: event ticks since start or last first event
    logic [31:0] span_r;
    logic [5:0]  e1_span_r;
    logic [31:0] span_exp;
    assign span_exp = {16'h0000, evt_eff[15:0]} << (`FIRST_EVENT_RESOLUTION_SHIFT * res_r);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || start_wor || start_rx || e0_hit || state_r == WOR_IDLE) begin
            span_r <= '0;
        end else if (tick) begin
            span_r <= span_r + 32'h00000001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in || e0_hit) begin
            e1_span_r <= '0;
        end else if (tick && e1_span_r != 6'h3f) begin
            e1_span_r <= e1_span_r + 6'h01;
        end
    end

    property p_first_event;
        @(posedge sys_clk_in) disable iff (rst_in)
        e0_hit && !$past(wr_in) |-> (span_r + 32'h00000001 == span_exp);
    endproperty
    a_first_event: assert property (p_first_event)
        else $error("first event fired at wrong tick count");

    property p_second_short;
        @(posedge sys_clk_in) disable iff (rst_in)
        e1_hit && dly_r <= 3'h2 && $stable(dly_r)
            |-> (e1_span_r + 6'h01 == 6'd4 + {2'h0, dly_r, 1'b0});
    endproperty
    a_second_short: assert property (p_second_short)
        else $error("short second-event delay is wrong");

    property p_second_long;
        @(posedge sys_clk_in) disable iff (rst_in)
        e1_hit && dly_r == 3'h7 |-> (e1_span_r == 6'd47);
    endproperty
    a_second_long: assert property (p_second_long)
        else $error("second-event delay for setting 7 is not 48");

    property p_cal_periodic;
        @(posedge sys_clk_in) disable iff (rst_in)
        e0_hit && state_r == WOR_SLEEP && !stop |=> ##1 (cal_busy_out == cal_en_r ||
                                                          $past(pd_wake, 2));
    endproperty
    a_cal_periodic: assert property (p_cal_periodic)
        else $error("calibration enable not honoured");

    property p_wake_cal;
        @(posedge sys_clk_in) disable iff (rst_in)
        pd_wake |-> ##2 (osc_on_out && cal_busy_out) ##1 (osc_on_out || pd_r);
    endproperty
    a_wake_cal: assert property (p_wake_cal)
        else $error("power-up did not start calibration");

    property p_unit_span;
        @(posedge sys_clk_in) disable iff (rst_in)
        unit && res_r == 2'h1 && $stable(res_r) |-> (pre_r == 15'd31);
    endproperty
    a_unit_span: assert property (p_unit_span)
        else $error("resolution unit span is wrong");

    property p_max_span;
        @(posedge sys_clk_in) disable iff (rst_in)
        (state_r != WOR_IDLE) |-> (span_r < 32'h80000000);
    endproperty
    a_max_span: assert property (p_max_span)
        else $error("timeout ran past the longest span");

    property p_rx_any_res;
        @(posedge sys_clk_in) disable iff (rst_in)
        start_rx && !stop |=> (state_r == WOR_RX_TIMEOUT) ##1 (state_out == WOR_RX_TIMEOUT);
    endproperty
    a_rx_any_res: assert property (p_rx_any_res)
        else $error("receive timeout refused");

endmodule : wor_timer

//--- sim/wor_timer_test.sv
`timescale 1ns/1ps
`include "wor_params.svh"

module wor_timer_test;
    import wor_pkg::*;

    // ======================================================================
    // bench settings: event divider kept at full length, short calibration
    localparam int DIV_T = 750;
    localparam int CAL_T = 2;

    logic             sys_clk = 1'b0;
    logic             rst;
    logic [7:0]       addr;
    logic [7:0]       wdata;
    logic             wr_en;
    logic             rd_en;
    logic [7:0]       rd_data;
    logic             ev0;
    logic             ev1;
    logic             cal_busy;
    logic             osc_on;
    wor_state_t       state;
    int               n_mismatch = 0;
    int               num_checks = 0;
    int               dly_tab [8] = '{4, 6, 8, 12, 16, 24, 32, 48};

    // ======================================================================
    // clock and device under test
    always #2 sys_clk = ~sys_clk;

    wor_timer #(.DIV(DIV_T), .CAL_TICKS(CAL_T)) uut (
        .sys_clk_in   (sys_clk),
        .rst_in       (rst),
        .addr_in      (addr),
        .wr_data_in   (wdata),
        .wr_in        (wr_en),
        .rd_in        (rd_en),
        .rd_data_out  (rd_data),
        .first_event_count_out   (ev0),
        .second_event_delay_out   (ev1),
        .cal_busy_out (cal_busy),
        .osc_on_out   (osc_on),
        .state_out    (state)
    );

    // ======================================================================
    // compare and report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : check

    // cycle count must land inside a window of ticks
    task automatic in_range(input string what, input int v, input int lo, input int hi);
        check(what, {31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask : in_range

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // ======================================================================
    // register port accesses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr

    // read data sampled in the single cycle after the strobe
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        check(what, rd_data, exp);
    endtask : rdchk

    // bounded wait: 0 first event, 1 second event, 2 calibration done
    task automatic wait_sig(input int sel, input int limit, output int n);
        logic hit;
        n   = 0;
        hit = 1'b0;
        #1;
        while (!hit && n < limit) begin
            case (sel)
                0: hit = (ev0 === 1'b1);
                1: hit = (ev1 === 1'b1);
                default: hit = (cal_busy === 1'b0);
            endcase
            if (!hit) begin
                @(posedge sys_clk);
                #1;
                n++;
            end
        end
        if (!hit) begin
            n_mismatch++;
            $display("unexpected hang waiting on event %0d", sel);
        end
    endtask : wait_sig

    // ======================================================================
    // watchdog, well beyond the expected 75k cycles
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end

    // ======================================================================
    // main sequence
    initial begin
        int         n;
        int         k;
        logic [2:0] dsel;
        rst   = 1'b1;
        addr  = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check("osc after reset", osc_on, 1'b0);
        check("state after reset", state, WOR_IDLE);
        // reset values and read timing
        rdchk("count hi", `WOR_OFS_EVT0_HI, 8'h87);
        rdchk("count lo", `WOR_OFS_EVT0_LO, 8'h6b);
        rdchk("ctrl reset", `WOR_OFS_CTRL, 8'hf8);
        @(posedge sys_clk);
        #1;
        check("read data released", rd_data, 8'h00);
        rdchk("unmapped", 8'h55, 8'h00);
        // start refused while powered down
        wr(`WOR_OFS_CMD, 8'h01);
        @(posedge sys_clk);
        #1;
        check("start while down", state, WOR_IDLE);
        // power up with reserved bit set: calibration starts at once
        wr(`WOR_OFS_CTRL, 8'h7c);
        @(posedge sys_clk);
        #1;
        check("osc on", osc_on, 1'b1);
        check("cal busy", cal_busy, 1'b1);
        wait_sig(2, 4000, n);
        in_range("cal length", n + 1, (CAL_T - 1) * DIV_T, CAL_T * DIV_T + 3);
        rdchk("ctrl readback", `WOR_OFS_CTRL, 8'h78);
        // second-event delay, calibration on only for setting 0, resolution 0
        for (int s = 0; s < 4; s++) begin
            dsel = s[2:0];
            k    = dly_tab[s] + 1;
            wr(`WOR_OFS_EVT0_HI, 8'h00);
            wr(`WOR_OFS_EVT0_LO, k[7:0]);
            wr(`WOR_OFS_CTRL, {1'b0, dsel, (s == 0), 3'h0});
            wr(`WOR_OFS_CMD, 8'h01);
            wait_sig(0, 20000, n);
            in_range("first event", n + 1, (k - 1) * DIV_T, k * DIV_T + 3);
            check("cal at event", cal_busy, (s == 0));
            check("sleeping", state, WOR_SLEEP);
            wait_sig(1, 40000, n);
            check("second event", n, dly_tab[s] * DIV_T);
            rdchk("status", `WOR_OFS_STATUS, 8'h09);
            wr(`WOR_OFS_CMD, 8'h04);
            @(posedge sys_clk);
            #1;
            check("stopped", state, WOR_IDLE);
        end
        // receive timeout at resolution 1: one count is 32 ticks
        wr(`WOR_OFS_EVT0_LO, 8'h01);
        wr(`WOR_OFS_CTRL, 8'h01);
        wr(`WOR_OFS_CMD, 8'h02);
        wait_sig(0, 30000, n);
        in_range("rx timeout", n + 1, 31 * DIV_T, 32 * DIV_T + 3);
        repeat (2) @(posedge sys_clk);
        #1;
        check("rx done", state, WOR_IDLE);
        // receive timeout accepted at the longest resolution
        wr(`WOR_OFS_CTRL, 8'h03);
        wr(`WOR_OFS_CMD, 8'h02);
        repeat (2) @(posedge sys_clk);
        #1;
        check("rx res 3", state, WOR_RX_TIMEOUT);
        rdchk("ctrl res 3", `WOR_OFS_CTRL, 8'h03);
        // power down forces the timer idle
        wr(`WOR_OFS_CTRL, 8'h83);
        repeat (2) @(posedge sys_clk);
        #1;
        check("osc off", osc_on, 1'b0);
        check("down idle", state, WOR_IDLE);
        wrap_up();
    end

endmodule : wor_timer_test
